// ### rtl/pmcr_regs.sv
// Power-control register slice: control, retention flags, unlock key
// and rail enables behind a byte-wide sub-address port.
// Assumes a serial front end turns bus frames into one-cycle strobes,
// and that the sequencer, comparator and seal are synchronous inputs.
`timescale 1ns/1ps

module pmcr_regs #(
   parameter logic [7:0] KEY_MASK = pmcr_pkg::KEY_MASK_DEFAULT,
   parameter int         NRAIL    = pmcr_pkg::RAIL_COUNT,
   parameter int         NSEQ     = pmcr_pkg::SEQ_RAILS,
   parameter int         NFLAG    = pmcr_pkg::FLAG_COUNT
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic             power_fail_out_n,
   input  wire logic             fresh_seal_status,
   input  wire logic             seq_load,
   input  wire logic [NSEQ-1:0]  seq_rails,
   input  wire logic             power_up,
   input  wire logic             from_suspend,
   input  wire logic [NFLAG-1:0] suspend_enabled,
   output logic      [7:0]       reg_rdata,
   output logic                  reg_rvalid,
   output logic      [NRAIL-1:0] rail_en,
   output logic                  off_req,
   output logic                  coin_cell_measure_start
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic             pf_en;
      logic             cc_go;
      logic [NRAIL-1:0] rails;
      logic             off;
      logic [7:0]       rdata;
      logic             rvalid;
   } pmcr_top_st_t;

   pmcr_top_st_t st;
   pmcr_top_st_t next_st;

   logic             grant;
   logic [NFLAG-1:0] flags;

   pmcr_unlock #(
      .KEY_MASK (KEY_MASK)
   ) u_unlock (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .grant     (grant)
   );

   pmcr_retain #(
      .N (NFLAG)
   ) u_retain (
      .mclk            (mclk),
      .rst             (rst),
      .ce              (ce),
      .power_up        (power_up),
      .from_suspend    (from_suspend),
      .suspend_enabled (suspend_enabled),
      .flags           (flags)
   );

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   function automatic logic [7:0] read_mux(input logic [7:0] addr);
      read_mux = pmcr_pkg::REG_RESET;
      case (addr)
         pmcr_pkg::ADDR_POWER_CONTROL: begin
            read_mux = {{pmcr_pkg::CTRL_PAD{1'b0}}, st.pf_en,
                        st.cc_go}; // R15
         end
         pmcr_pkg::ADDR_RETAIN_FLAGS: begin
            read_mux = flags; // R06
         end
         pmcr_pkg::ADDR_UNLOCK_KEY: begin
            read_mux = pmcr_pkg::KEY_READBACK; // R07
         end
         pmcr_pkg::ADDR_RAIL_ENABLES: begin
            read_mux = {{pmcr_pkg::RAIL_PAD{1'b0}}, st.rails}; // R09
         end
         default: begin
            read_mux = pmcr_pkg::REG_RESET;
         end
      endcase
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.rvalid = 1'b0;
         // Start pulse lasts one cycle only
         next_st.cc_go  = 1'b0; // R03
         if (reg_wr && reg_addr == pmcr_pkg::ADDR_POWER_CONTROL) begin
            next_st.pf_en = reg_wdata[pmcr_pkg::CTRL_PF_BIT];
            next_st.cc_go = reg_wdata[pmcr_pkg::CTRL_CC_BIT]; // R03
         end
         if (grant) begin
            next_st.rails = reg_wdata[NRAIL-1:0]; // R09
            // Broken seal: backup rails may be set but not cleared
            if (fresh_seal_status) begin // R13
               next_st.rails[pmcr_pkg::BACKUP_HI:pmcr_pkg::BACKUP_LO] =
                  st.rails[pmcr_pkg::BACKUP_HI:pmcr_pkg::BACKUP_LO] |
                  reg_wdata[pmcr_pkg::BACKUP_HI:pmcr_pkg::BACKUP_LO]; // R10
            end
         end
         // Sequencer outranks software on rails it owns
         if (seq_load) begin
            next_st.rails[NSEQ-1:0] = seq_rails; // R11
         end
         // Comparator only acts when shutdown is armed
         next_st.off = st.pf_en && !power_fail_out_n; // R01 R02
         if (next_st.off) begin
            next_st.rails = '0; // R02
         end
         if (reg_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_mux(reg_addr);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0; // R12
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata               = st.rdata;
   assign reg_rvalid              = st.rvalid;
   assign rail_en                 = st.rails;
   assign off_req                 = st.off;
   assign coin_cell_measure_start = st.cc_go;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_PF_IGNORED: assert property (@(posedge mclk) disable iff (rst) // R01
      ce && !st.pf_en |=> !off_req)
      else $error("shutdown raised while power-fail disabled");

   AST_PF_SHUTDOWN: assert property (@(posedge mclk) disable iff (rst) // R02
      ce && st.pf_en && !power_fail_out_n |=> off_req && rail_en == '0)
      else $error("power-fail trip did not shut all rails");

   AST_CC_PULSE: assert property (@(posedge mclk) disable iff (rst) // R03
      ce && reg_wr && reg_addr == pmcr_pkg::ADDR_POWER_CONTROL
      && reg_wdata[pmcr_pkg::CTRL_CC_BIT]
      |=> coin_cell_measure_start ##1 (!$past(ce) || !coin_cell_measure_start
      || $past(reg_wr && reg_addr == pmcr_pkg::ADDR_POWER_CONTROL
      && reg_wdata[pmcr_pkg::CTRL_CC_BIT])))
      else $error("coin measurement start did not self-clear");

   AST_KEY_READ_ZERO: assert property (@(posedge mclk) disable iff (rst) // R07
      ce && reg_rd && reg_addr == pmcr_pkg::ADDR_UNLOCK_KEY
      |=> reg_rvalid && reg_rdata == pmcr_pkg::KEY_READBACK)
      else $error("key register read back nonzero");

   AST_RAIL_PAD_ZERO: assert property (@(posedge mclk) disable iff (rst) // R09
      ce && reg_rd && reg_addr == pmcr_pkg::ADDR_RAIL_ENABLES
      |=> reg_rvalid && reg_rdata[7:NRAIL] == '0
      && reg_rdata[NRAIL-1:0] == $past(rail_en))
      else $error("rail enable read wrong");

   AST_CTRL_PAD_ZERO: assert property (@(posedge mclk) disable iff (rst) // R15
      ce && reg_rd && reg_addr == pmcr_pkg::ADDR_POWER_CONTROL
      |=> reg_rdata[7:2] == '0 && reg_rdata[1] == $past(st.pf_en))
      else $error("control read wrong");

   AST_BACKUP_HELD: assert property (@(posedge mclk) disable iff (rst) // R10
      ce && grant && fresh_seal_status && !seq_load
      && !(st.pf_en && !power_fail_out_n)
      |=> (rail_en[pmcr_pkg::BACKUP_HI:pmcr_pkg::BACKUP_LO]
      & $past(rail_en[pmcr_pkg::BACKUP_HI:pmcr_pkg::BACKUP_LO]))
      == $past(rail_en[pmcr_pkg::BACKUP_HI:pmcr_pkg::BACKUP_LO]))
      else $error("backup rail cleared with seal broken");

   AST_SEQ_LOAD: assert property (@(posedge mclk) disable iff (rst) // R11
      ce && seq_load && !(st.pf_en && !power_fail_out_n)
      |=> rail_en[NSEQ-1:0] == $past(seq_rails))
      else $error("sequencer rail update lost");

   AST_NO_UNLOCK: assert property (@(posedge mclk) disable iff (rst) // R16
      ce && reg_wr && reg_addr == pmcr_pkg::ADDR_RAIL_ENABLES && !grant
      && !seq_load && !(st.pf_en && !power_fail_out_n)
      |=> $stable(rail_en))
      else $error("locked rail write took effect");

   AST_FLAG_READ: assert property (@(posedge mclk) disable iff (rst) // R06
      ce && reg_rd && reg_addr == pmcr_pkg::ADDR_RETAIN_FLAGS
      && !power_up |=> reg_rdata == $past(flags))
      else $error("flag register read wrong");

endmodule

// ### rtl/pmcr_pkg.sv
// Constants shared by the power-control register slice.
// Assumes one synchronous clock domain and a byte-wide sub-address port.
//
// How it works
// R01 - Power-fail enable clear ignores comparator
// R02 - Enabled and comparator low: all rails off
// R03 - Writing one starts coin measurement, self-clears
// R04 - Retention flag set if enabled during suspend
// R05 - Retention flag zero after off power-up
// R06 - Flag bits: outputs, linear, rails four-one
// R07 - Key register always reads zero
// R08 - Key writes unlock protected register access
// R09 - Rail bits five-zero enable; seven-six zero
// R10 - Backup rails not disabled while seal broken; a sequencer load can still clear bit 4, and a power-fail trip clears both
// R11 - Sequencer updates rails one to five
// R12 - Sub-addresses fixed; every register resets zero
// R13 - Seal status zero fresh, one broken
// R14 - Host measures coin cell before trusting level
// R15 - Reserved bits ignore writes, read zero
// R16 - Protected writes without unlock are discarded

package pmcr_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h06;
   localparam logic [7:0] ADDR_RETAIN_FLAGS  = 8'h07;
   localparam logic [7:0] ADDR_UNLOCK_KEY    = 8'h10;
   localparam logic [7:0] ADDR_RAIL_ENABLES  = 8'h11;
   localparam logic [7:0] REG_RESET          = 8'h00;
   localparam logic [7:0] KEY_READBACK       = 8'h00;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int CTRL_CC_BIT   = 0;
   localparam int CTRL_PF_BIT   = 1;
   localparam int RAIL_COUNT    = 6;
   localparam int SEQ_RAILS     = 5;
   localparam int BACKUP_LO     = 4;
   localparam int BACKUP_HI     = 5;
   localparam int FLAG_COUNT    = 8;
   localparam int CTRL_PAD      = 6;
   localparam int RAIL_PAD      = 2;

   // Default unlock mask; value is arbitrary
   localparam logic [7:0] KEY_MASK_DEFAULT = 8'h5a;

   function automatic logic is_protected(input logic [7:0] addr);
      is_protected = (addr == ADDR_RAIL_ENABLES);
   endfunction

endpackage

// ### rtl/pmcr_unlock.sv
// Key-register unlock tracker for protected writes.
// Assumes the write strobe is one cycle wide per register write.
`timescale 1ns/1ps

module pmcr_unlock #(
   parameter logic [7:0] KEY_MASK = pmcr_pkg::KEY_MASK_DEFAULT
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   output logic            grant
);

   typedef struct packed {
      logic       armed;
      logic [7:0] key;
   } pmcr_unl_st_t;

   pmcr_unl_st_t st;
   pmcr_unl_st_t next_st;

   // Key must match target address under the mask, one write ahead
   assign grant = reg_wr && st.armed && pmcr_pkg::is_protected(reg_addr)
                  && (st.key == (reg_addr ^ KEY_MASK)); // R16

   always_comb begin
      next_st = st;
      if (ce && reg_wr) begin
         if (reg_addr == pmcr_pkg::ADDR_UNLOCK_KEY) begin
            next_st.armed = 1'b1; // R08
            next_st.key   = reg_wdata;
         end else begin
            // Any other write spends the unlock
            next_st.armed = 1'b0; // R16
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   AST_KEY_ARMS: assert property (@(posedge mclk) disable iff (rst) // R08
      ce && reg_wr && reg_addr == pmcr_pkg::ADDR_UNLOCK_KEY
      |=> st.armed && st.key == $past(reg_wdata))
      else $error("key write did not arm unlock");

   AST_UNLOCK_SPENT: assert property (@(posedge mclk) disable iff (rst) // R16
      ce && reg_wr && reg_addr != pmcr_pkg::ADDR_UNLOCK_KEY
      |=> !st.armed ##0 !grant)
      else $error("unlock survived a non-key write");

endmodule

// ### rtl/pmcr_retain.sv
// Suspend-retention flags, captured at each power-up.
// Assumes power_up is a one-cycle pulse from the power sequencer.
`timescale 1ns/1ps

module pmcr_retain #(
   parameter int N = pmcr_pkg::FLAG_COUNT
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         power_up,
   input  wire logic         from_suspend,
   input  wire logic [N-1:0] suspend_enabled,
   output logic      [N-1:0] flags
);

   typedef struct packed {
      logic [N-1:0] flags;
   } pmcr_ret_st_t;

   pmcr_ret_st_t st;
   pmcr_ret_st_t next_st;

   assign flags = st.flags;

   always_comb begin
      next_st = st;
      if (ce && power_up) begin
         if (from_suspend) begin
            next_st.flags = suspend_enabled; // R04
         end else begin
            next_st.flags = '0; // R05
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   AST_FLAGS_SUSPEND: assert property (@(posedge mclk) disable iff (rst) // R04
      ce && power_up && from_suspend |=> flags == $past(suspend_enabled))
      else $error("retention flags do not match suspend enables");

   AST_FLAGS_OFF: assert property (@(posedge mclk) disable iff (rst) // R05
      ce && power_up && !from_suspend |=> flags == '0)
      else $error("retention flags not cleared after off power-up");

endmodule

// ### sim/pmcr_host.sv
// Host model: register reads and writes on the strobe port.
// Assumes tasks are entered just after a rising mclk edge.
`timescale 1ns/1ps

module pmcr_host (
   input  wire logic       mclk,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      // Released lines flip so stale values never look valid
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      reg_wr    <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_addr <= ~a;
      reg_rd   <= 1'b0;
      // Answer stands one cycle; taken at the edge that closes it
      @(posedge mclk);
      v = reg_rvalid;
      d = reg_rdata;
   endtask

   // Key write, then the protected write as the very next write
   task automatic wr_prot(input logic [7:0] a, input logic [7:0] d);
      wr(pmcr_pkg::ADDR_UNLOCK_KEY, a ^ pmcr_pkg::KEY_MASK_DEFAULT);
      wr(a, d);
   endtask

   // Level bits are only trusted after a fresh measurement
   task automatic measure(input logic pf_keep);
      wr(pmcr_pkg::ADDR_POWER_CONTROL, {6'h00, pf_keep, 1'b1});
   endtask
endmodule

// ### sim/pmcr_regs_bench.sv
// Self-checking bench for the power-control register slice.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/1ps

module pmcr_regs_bench;
   logic       mclk, rst, ce, reg_wr, reg_rd, reg_rvalid, off_req;
   logic       power_fail_out_n, fresh_seal_status, seq_load;
   logic       power_up, from_suspend, coin_cell_measure_start;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, suspend_enabled;
   logic [4:0] seq_rails;
   logic [5:0] rail_en;
   int         fails, num_checks, cycles, pulses;

   pmcr_regs dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .power_fail_out_n(power_fail_out_n),
      .fresh_seal_status(fresh_seal_status), .seq_load(seq_load),
      .seq_rails(seq_rails), .power_up(power_up),
      .from_suspend(from_suspend), .suspend_enabled(suspend_enabled),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rail_en(rail_en),
      .off_req(off_req),
      .coin_cell_measure_start(coin_cell_measure_start));

   pmcr_host host (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      host.rd(a, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, exp);
   endtask

   task automatic power_cycle(input logic susp, input logic [7:0] en);
      suspend_enabled <= en;
      from_suspend    <= susp;
      power_up        <= 1'b1;
      @(posedge mclk);
      power_up <= 1'b0;
   endtask

   task automatic finish_test();
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Sampled mid-cycle so a one-cycle pulse counts exactly once
   always @(negedge mclk) begin
      if (coin_cell_measure_start === 1'b1) begin
         pulses++;
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rst, ce, power_fail_out_n} = 3'b111;
      {fresh_seal_status, seq_load, power_up, from_suspend} = 4'h0;
      seq_rails = 5'h00;
      suspend_enabled = 8'h00;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdc(8'h06, 8'h00);
      rdc(8'h07, 8'h00);
      rdc(8'h10, 8'h00);
      rdc(8'h11, 8'h00);
      rdc(8'h20, 8'h00);
      host.wr(8'h10, 8'ha5);
      rdc(8'h10, 8'h00);
      host.wr(8'h11, 8'h0f);
      rdc(8'h11, 8'h00);
      host.wr(8'h10, 8'h11 ^ pmcr_pkg::KEY_MASK_DEFAULT);
      host.wr(8'h06, 8'h00);
      host.wr(8'h11, 8'h0f);
      rdc(8'h11, 8'h00);
      fresh_seal_status <= 1'b1;
      host.wr_prot(8'h11, 8'hff);
      rdc(8'h11, 8'h3f);
      chk({2'b00, rail_en}, 8'h3f);
      host.wr_prot(8'h11, 8'h00);
      rdc(8'h11, 8'h30);
      fresh_seal_status <= 1'b0;
      host.wr_prot(8'h11, 8'h0f);
      rdc(8'h11, 8'h0f);
      host.wr(8'h06, 8'hfc);
      rdc(8'h06, 8'h00);
      chk(8'(pulses), 8'h00);
      host.measure(1'b0);
      rdc(8'h06, 8'h00);
      chk(8'(pulses), 8'h01);
      power_fail_out_n <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({7'h00, off_req}, 8'h00);
      chk({2'b00, rail_en}, 8'h0f);
      host.wr(8'h06, 8'h02);
      @(negedge mclk);
      chk({7'h00, off_req}, 8'h01);
      chk({2'b00, rail_en}, 8'h00);
      @(posedge mclk);
      power_fail_out_n <= 1'b1;
      host.wr(8'h06, 8'h00);
      seq_rails <= 5'h15;
      seq_load  <= 1'b1;
      @(posedge mclk);
      seq_load <= 1'b0;
      rdc(8'h11, 8'h15);
      power_cycle(1'b1, 8'ha5);
      rdc(8'h07, 8'ha5);
      host.wr(8'h07, 8'hff);
      rdc(8'h07, 8'ha5);
      power_cycle(1'b1, 8'h5a);
      rdc(8'h07, 8'h5a);
      power_cycle(1'b0, 8'hff);
      rdc(8'h07, 8'h00);
      // Clock enable low: a start write must not pulse
      ce <= 1'b0;
      host.measure(1'b0);
      ce <= 1'b1;
      chk(8'(pulses), 8'h01);
      // Mid-run reset must drop rails and a pending unlock
      host.wr(8'h10, 8'h11 ^ pmcr_pkg::KEY_MASK_DEFAULT);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      host.wr(8'h11, 8'h3f);
      rdc(8'h11, 8'h00);
      finish_test();
   end
endmodule
